// [rtl/vac_consts.vh]
// vac_consts.vh: offsets, field positions, reset values and op codes
// assumes: included by the vac design files, byte addresses on the bus
`ifndef VAC_CONSTS_VH
`define VAC_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define VAC_OFF_CMD       8'h00
`define VAC_OFF_ACC_A     8'h04
`define VAC_OFF_ACC_B     8'h08
`define VAC_OFF_MULT_T    8'h0C
`define VAC_OFF_OPER_X    8'h10
`define VAC_OFF_OPER_Y    8'h14
`define VAC_OFF_HISTORY   8'h18
`define VAC_OFF_STATUS    8'h1C
`define VAC_OFF_SELECTED  8'h20
`define VAC_OFF_CS_BRC    8'h24
`define VAC_OFF_CS_MULT   8'h28
`define VAC_OFF_CS_ACC    8'h2C
`define VAC_OFF_BRC       8'h30
`define VAC_OFF_SOFT      8'h34
`define VAC_OFF_BFLY      8'h38
`define VAC_OFF_MODE      8'h3C
`define VAC_OFF_METRIC    8'h40

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define VAC_CMD_OP_MSB    3
`define VAC_CMD_ACC_SEL   4
`define VAC_STAT_TEST     0
`define VAC_STAT_DONE     1
`define VAC_MODE_DUAL     0

// ----------------------------------------------------------------------
// op codes
// ----------------------------------------------------------------------
`define VAC_OP_NOP        4'h0
`define VAC_OP_ADD_SUB    4'h1
`define VAC_OP_SUB_ADD    4'h2
`define VAC_OP_CMP_SEL    4'h3
`define VAC_OP_SQUARE     4'h4
`define VAC_OP_MULT_ACC   4'h5
`define VAC_OP_MULT_SUB   4'h6
`define VAC_OP_COND_STORE 4'h7
`define VAC_OP_BRANCH_M   4'h8

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define VAC_RST_WORD      32'h0000_0000
`define VAC_RST_HALF      16'h0000
`define VAC_RST_MODE      1'b1
`define VAC_NUM_STATES    16
`define VAC_LAST_BFLY     3'h7

`endif

// [rtl/vac_dual_alu.v]
// vac_dual_alu.v: split or full width add/subtract unit
// assumes: purely combinational, used by vac_datapath
`timescale 1ns/1ps
`default_nettype none

module vac_dual_alu #(
    parameter HALF_W = 16
) (
    input  wire [2*HALF_W-1:0] a_i,
    input  wire [2*HALF_W-1:0] b_i,
    input  wire                sub_hi_i,
    input  wire                sub_lo_i,
    input  wire                dual_i,
    output wire [2*HALF_W-1:0] y_o
);

// ----------------------------------------------------------------------
// halves never pass a carry in dual mode
// ----------------------------------------------------------------------
wire [HALF_W-1:0]   hi_y;
wire [HALF_W-1:0]   lo_y;
wire [2*HALF_W-1:0] full_y;

assign hi_y   = sub_hi_i ? a_i[2*HALF_W-1:HALF_W] - b_i[2*HALF_W-1:HALF_W]
                         : a_i[2*HALF_W-1:HALF_W] + b_i[2*HALF_W-1:HALF_W];
assign lo_y   = sub_lo_i ? a_i[HALF_W-1:0] - b_i[HALF_W-1:0]
                         : a_i[HALF_W-1:0] + b_i[HALF_W-1:0];
assign full_y = sub_hi_i ? a_i - b_i : a_i + b_i;
assign y_o    = dual_i ? {hi_y, lo_y} : full_y;

endmodule // vac_dual_alu

`default_nettype wire

// [rtl/vac_branch_metric.v]
// vac_branch_metric.v: branch metric from two soft symbols
// assumes: combinational, butterfly index from vac_datapath
`timescale 1ns/1ps
`default_nettype none

module vac_branch_metric #(
    parameter DATA_W = 16
) (
    input  wire [DATA_W-1:0] soft0_i,
    input  wire [DATA_W-1:0] soft1_i,
    input  wire [2:0]        bfly_i,
    output wire [DATA_W-1:0] metric_o
);

// ----------------------------------------------------------------------
// code signs: first negative on odd index, second flips above 3
// ----------------------------------------------------------------------
wire              neg0;
wire              neg1;
wire [DATA_W-1:0] term0;
wire [DATA_W-1:0] term1;

assign neg0     = bfly_i[0];
assign neg1     = bfly_i[0] ^ bfly_i[2];
assign term0    = neg0 ? (~soft0_i + 1'b1) : soft0_i;
assign term1    = neg1 ? (~soft1_i + 1'b1) : soft1_i;
assign metric_o = term0 + term1;

endmodule // vac_branch_metric

`default_nettype wire

// [rtl/vac_datapath.v]
// vac_datapath.v: add-compare-select and codebook search datapath
// assumes: single 250 MHz clock, Avalon-MM slave with waitrequest
//
// Functional notes
// - dual mode splits accumulator into halves
// - add-sub op: old plus, other minus
// - sub-add op: opposite metric signs
// - compare-select stores larger accumulator half
// - history register updates every compare-select
// - shift history, insert outcome, set flag
// - sixteen states as eight butterflies
// - rate half, constraint five code
// - metric is signed sum of symbols
// - fixed code sign table per butterfly
// - conditional stores only when B nonnegative
// - multiply-subtract from B, load operand
// - search compares ratios by cross-multiplying
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`include "vac_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module vac_datapath #(
    parameter DATA_W = 16
) (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire [7:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    output wire        test_flag_o
);

// ----------------------------------------------------------------------
// bus slave: one wait state per access
// ----------------------------------------------------------------------
reg         ack_reg;
reg  [31:0] rdata_reg;
wire        access;
wire        wr_go;
wire [7:0]  addr;

assign access            = avs_read_i | avs_write_i;
assign avs_waitrequest_o = access & ~ack_reg;
assign avs_readdata_o    = rdata_reg;
assign wr_go             = avs_write_i & ack_reg;
assign addr              = {avs_address_i[7:2], 2'b00};

always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
        ack_reg <= 1'b0;
    else
        ack_reg <= access & ~ack_reg;
end

function [31:0] merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0]  be;
    integer      k;
    begin
        merge = old_w;
        for (k = 0; k < 4; k = k + 1)
            if (be[k])
                merge[8*k+:8] = new_w[8*k+:8];
    end
endfunction

// ----------------------------------------------------------------------
// state registers
// ----------------------------------------------------------------------
reg  [31:0]       acc_a_reg;
reg  [31:0]       acc_b_reg;
reg  [DATA_W-1:0] mult_t_reg;
reg  [DATA_W-1:0] oper_x_reg;
reg  [DATA_W-1:0] oper_y_reg;
reg  [DATA_W-1:0] decision_history_reg;
reg               test_flag_reg;
reg               done_reg;
reg  [DATA_W-1:0] selected_reg;
reg  [DATA_W-1:0] cs_brc_reg;
reg  [DATA_W-1:0] cs_mult_reg;
reg  [DATA_W-1:0] cs_acc_reg;
reg  [DATA_W-1:0] block_repeat_counter;
reg  [DATA_W-1:0] soft0_reg;
reg  [DATA_W-1:0] soft1_reg;
reg  [2:0]        bfly_reg;
reg               dual_reg;
reg  [DATA_W-1:0] metric_mem [0:`VAC_NUM_STATES-1];

assign test_flag_o = test_flag_reg;

// ----------------------------------------------------------------------
// command decode
// ----------------------------------------------------------------------
wire       cmd_go;
wire [3:0] op;
wire       acc_sel;
wire       op_add_sub;
wire       op_sub_add;
wire       op_cmp_sel;
wire       op_square;
wire       op_mult_acc;
wire       op_mult_sub;
wire       op_cond;
wire       op_bm;

assign cmd_go      = wr_go & (addr == `VAC_OFF_CMD) & avs_byteenable_i[0];
assign op          = avs_writedata_i[`VAC_CMD_OP_MSB:0];
assign acc_sel     = avs_writedata_i[`VAC_CMD_ACC_SEL];
assign op_add_sub  = cmd_go & (op == `VAC_OP_ADD_SUB);
assign op_sub_add  = cmd_go & (op == `VAC_OP_SUB_ADD);
assign op_cmp_sel  = cmd_go & (op == `VAC_OP_CMP_SEL);
assign op_square   = cmd_go & (op == `VAC_OP_SQUARE);
assign op_mult_acc = cmd_go & (op == `VAC_OP_MULT_ACC);
assign op_mult_sub = cmd_go & (op == `VAC_OP_MULT_SUB);
assign op_cond     = cmd_go & (op == `VAC_OP_COND_STORE);
assign op_bm       = cmd_go & (op == `VAC_OP_BRANCH_M);

// ----------------------------------------------------------------------
// arithmetic
// ----------------------------------------------------------------------
wire [31:0]       old_pair;
wire [31:0]       t_pair;
wire [31:0]       alu_y;
wire              alu_sub_hi;
wire [DATA_W-1:0] metric;
wire [31:0]       src_acc;
wire [DATA_W-1:0] src_hi;
wire [DATA_W-1:0] src_lo;
wire              lo_wins;
wire [DATA_W-1:0] larger;
wire [31:0]       prod_xx;
wire [31:0]       prod_ax;
wire [31:0]       prod_xy;
wire              b_nonneg;
wire [3:0]        dest_idx;

assign old_pair   = {oper_x_reg, oper_y_reg};
assign t_pair     = dual_reg ? {mult_t_reg, mult_t_reg}
                             : {{DATA_W{mult_t_reg[DATA_W-1]}}, mult_t_reg};
assign alu_sub_hi = op_sub_add;

vac_dual_alu #(
    .HALF_W (DATA_W)
) u_alu (
    .a_i      (old_pair),
    .b_i      (t_pair),
    .sub_hi_i (alu_sub_hi),
    .sub_lo_i (~alu_sub_hi),
    .dual_i   (dual_reg),
    .y_o      (alu_y)
);

vac_branch_metric #(
    .DATA_W (DATA_W)
) u_bm (
    .soft0_i  (soft0_reg),
    .soft1_i  (soft1_reg),
    .bfly_i   (bfly_reg),
    .metric_o (metric)
);

assign src_acc  = acc_sel ? acc_b_reg : acc_a_reg;
assign src_hi   = src_acc[31:16];
assign src_lo   = src_acc[15:0];
assign lo_wins  = $signed(src_lo) > $signed(src_hi);
assign larger   = lo_wins ? src_lo : src_hi;
assign dest_idx = {acc_sel, bfly_reg};
assign prod_xx  = $signed(oper_x_reg) * $signed(oper_x_reg);
assign prod_ax  = $signed(acc_a_reg[31:16]) * $signed(oper_x_reg);
assign prod_xy  = $signed(oper_x_reg) * $signed(oper_y_reg);
assign b_nonneg = ~acc_b_reg[31];

// ----------------------------------------------------------------------
// accumulators and operand registers
// ----------------------------------------------------------------------
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        acc_a_reg  <= `VAC_RST_WORD;
        acc_b_reg  <= `VAC_RST_WORD;
        mult_t_reg <= `VAC_RST_HALF;
        oper_x_reg <= `VAC_RST_HALF;
        oper_y_reg <= `VAC_RST_HALF;
    end
    else
    begin
        if (op_add_sub | op_sub_add)
        begin
            if (acc_sel)
                acc_b_reg <= alu_y;
            else
                acc_a_reg <= alu_y;
        end
        else if (op_square)
            acc_a_reg <= prod_xx;
        else if (op_mult_acc)
            acc_b_reg <= prod_ax;
        else if (op_mult_sub)
        begin
            acc_b_reg  <= acc_b_reg - prod_xy;
            mult_t_reg <= oper_x_reg;
        end
        else if (op_bm)
            mult_t_reg <= metric;
        else if (wr_go)
        begin
            case (addr)
                `VAC_OFF_ACC_A:
                    acc_a_reg <= merge(acc_a_reg, avs_writedata_i,
                                       avs_byteenable_i);
                `VAC_OFF_ACC_B:
                    acc_b_reg <= merge(acc_b_reg, avs_writedata_i,
                                       avs_byteenable_i);
                `VAC_OFF_MULT_T:
                    mult_t_reg <= avs_writedata_i[15:0];
                `VAC_OFF_OPER_X:
                    oper_x_reg <= avs_writedata_i[15:0];
                `VAC_OFF_OPER_Y:
                    oper_y_reg <= avs_writedata_i[15:0];
                default:
                    acc_a_reg <= acc_a_reg;
            endcase
        end
    end
end

// ----------------------------------------------------------------------
// compare-select, decision history, butterfly index
// ----------------------------------------------------------------------
wire hist_wr;
wire stat_wr;
wire last_bfly;

assign hist_wr   = wr_go & (addr == `VAC_OFF_HISTORY);
assign stat_wr   = wr_go & (addr == `VAC_OFF_STATUS);
assign last_bfly = op_cmp_sel & acc_sel & (bfly_reg == `VAC_LAST_BFLY);

always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        decision_history_reg <= `VAC_RST_HALF;
        test_flag_reg        <= 1'b0;
        selected_reg         <= `VAC_RST_HALF;
        bfly_reg             <= 3'h0;
        done_reg             <= 1'b0;
    end
    else
    begin
        if (op_cmp_sel)
        begin
            decision_history_reg <= {decision_history_reg[DATA_W-2:0],
                                     lo_wins};
            test_flag_reg        <= lo_wins;
            selected_reg         <= larger;
        end
        else if (hist_wr)
            decision_history_reg <= avs_writedata_i[15:0];
        if (op_cmp_sel & acc_sel)
            bfly_reg <= bfly_reg + 3'h1;
        else if (wr_go & (addr == `VAC_OFF_BFLY))
            bfly_reg <= avs_writedata_i[2:0];
        if (last_bfly)
            done_reg <= 1'b1;
        else if (stat_wr & avs_writedata_i[`VAC_STAT_DONE])
            done_reg <= 1'b0;
    end
end

always @(posedge clk_i)
begin
    if (op_cmp_sel)
        metric_mem[dest_idx] <= larger;
end

// ----------------------------------------------------------------------
// conditional stores, repeat counter, soft symbols, mode
// ----------------------------------------------------------------------
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        cs_brc_reg           <= `VAC_RST_HALF;
        cs_mult_reg          <= `VAC_RST_HALF;
        cs_acc_reg           <= `VAC_RST_HALF;
        block_repeat_counter <= `VAC_RST_HALF;
        soft0_reg            <= `VAC_RST_HALF;
        soft1_reg            <= `VAC_RST_HALF;
        dual_reg             <= `VAC_RST_MODE;
    end
    else
    begin
        if (op_cond & b_nonneg)
        begin
            cs_brc_reg  <= block_repeat_counter;
            cs_mult_reg <= mult_t_reg;
            cs_acc_reg  <= acc_a_reg[31:16];
        end
        if (wr_go)
        begin
            case (addr)
                `VAC_OFF_BRC:
                    block_repeat_counter <= avs_writedata_i[15:0];
                `VAC_OFF_SOFT:
                begin
                    soft0_reg <= avs_writedata_i[15:0];
                    soft1_reg <= avs_writedata_i[31:16];
                end
                `VAC_OFF_MODE:
                    dual_reg <= avs_writedata_i[`VAC_MODE_DUAL];
                default:
                    dual_reg <= dual_reg;
            endcase
        end
    end
end

// ----------------------------------------------------------------------
// read mux, sampled in the wait cycle
// ----------------------------------------------------------------------
reg [31:0] rd_next;

always @*
begin
    rd_next = 32'h0000_0000;
    if (addr >= `VAC_OFF_METRIC)
    begin
        if (addr < `VAC_OFF_METRIC + 8'h40)
            rd_next = {16'h0000, metric_mem[addr[5:2]]};
    end
    else
    begin
        case (addr)
            `VAC_OFF_ACC_A:    rd_next = acc_a_reg;
            `VAC_OFF_ACC_B:    rd_next = acc_b_reg;
            `VAC_OFF_MULT_T:   rd_next = {16'h0000, mult_t_reg};
            `VAC_OFF_OPER_X:   rd_next = {16'h0000, oper_x_reg};
            `VAC_OFF_OPER_Y:   rd_next = {16'h0000, oper_y_reg};
            `VAC_OFF_HISTORY:  rd_next = {16'h0000, decision_history_reg};
            `VAC_OFF_STATUS:   rd_next = {30'h0000_0000, done_reg,
                                          test_flag_reg};
            `VAC_OFF_SELECTED: rd_next = {16'h0000, selected_reg};
            `VAC_OFF_CS_BRC:   rd_next = {16'h0000, cs_brc_reg};
            `VAC_OFF_CS_MULT:  rd_next = {16'h0000, cs_mult_reg};
            `VAC_OFF_CS_ACC:   rd_next = {16'h0000, cs_acc_reg};
            `VAC_OFF_BRC:      rd_next = {16'h0000, block_repeat_counter};
            `VAC_OFF_SOFT:     rd_next = {soft1_reg, soft0_reg};
            `VAC_OFF_BFLY:     rd_next = {29'h0000_0000, bfly_reg};
            `VAC_OFF_MODE:     rd_next = {31'h0000_0000, dual_reg};
            default:           rd_next = 32'h0000_0000;
        endcase
    end
end

always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
        rdata_reg <= `VAC_RST_WORD;
    else if (avs_read_i & ~ack_reg)
        rdata_reg <= rd_next;
end

endmodule // vac_datapath

`default_nettype wire

// [dv/vac_datapath_asserts.sv]
// vac_datapath_asserts.sv: port checker for the datapath
// assumes: bound to vac_datapath, one clock, one wait state per access
`timescale 1ns/1ps
`default_nettype none
`include "vac_consts.vh"

module vac_datapath_chk (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        test_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // ----------------------------------------------------------
    // completed accesses
    // ----------------------------------------------------------
    wire logic req = avs_read_i | avs_write_i;
    wire logic rd_done = avs_read_i & ~avs_waitrequest_o;
    wire logic wr_done = avs_write_i & ~avs_waitrequest_o;
    wire logic cmp_done = wr_done & (avs_address_i[7:2] == 6'h00)
        & avs_byteenable_i[0]
        & (avs_writedata_i[3:0] == `VAC_OP_CMP_SEL);
    logic hist_wr_reg;
    logic seen_cmp_reg;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            hist_wr_reg <= 1'b0;
            seen_cmp_reg <= 1'b0;
        end
        else if (cmp_done)
        begin
            hist_wr_reg <= 1'b0;
            seen_cmp_reg <= 1'b1;
        end
        else if (wr_done
                 && {avs_address_i[7:2], 2'b00} == `VAC_OFF_HISTORY)
            hist_wr_reg <= 1'b1;
    end

    // ----------------------------------------------------------
    // properties
    // ----------------------------------------------------------
    AST_WAIT_ONE: assert property (req && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("wait longer than one");
    AST_RD_SEQ: assert property ($rose(avs_read_i)
        |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("read wait state wrong");
    AST_IDLE: assert property (!req |-> !avs_waitrequest_o)
        else $error("wait without request");
    AST_RD_HOLD: assert property (!avs_read_i |=> $stable(avs_readdata_o))
        else $error("read data moved without read");
    AST_UNMAPPED: assert property (rd_done && avs_address_i >= 8'h80
        |-> avs_readdata_o == 32'h0) else $error("unmapped read not 0");
    AST_FLAG_CMP: assert property (
        $changed(test_flag_o) |-> $past(cmp_done))
        else $error("flag moved without compare");
    AST_STATUS_FLAG: assert property (rd_done
        && avs_address_i == `VAC_OFF_STATUS
        |-> avs_readdata_o[0] == test_flag_o) else $error("status flag");
    AST_HIST_LSB: assert property (rd_done && seen_cmp_reg
        && !hist_wr_reg && avs_address_i == `VAC_OFF_HISTORY
        |-> avs_readdata_o[0] == test_flag_o) else $error("history lsb");

    CV_CMP: cover property (cmp_done);
    CV_FLAG: cover property ($rose(test_flag_o));
    CV_UNMAPPED: cover property (rd_done && avs_address_i >= 8'h80);
endmodule // vac_datapath_chk

bind vac_datapath vac_datapath_chk u_vac_datapath_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .test_flag_o(test_flag_o));
`default_nettype wire

// [dv/tb.sv]
// tb.sv: directed bench for the add-compare-select datapath
// assumes: vac_datapath from rtl, one Avalon master at a time
`timescale 1ns/1ps
`default_nettype none
`include "vac_consts.vh"

module tb;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hF;
    logic [31:0] rdata;
    logic        wait_o;
    logic        flag;
    int          err_count = 0;
    int          n_compared = 0;
    logic [31:0] v;
    logic [15:0] hist, hi, lo, sel, m;
    logic        tc;
    // negative code signs per butterfly, bit J
    localparam logic [7:0] NEG0 = 8'hAA;
    localparam logic [7:0] NEG1 = 8'h5A;

    always #2 clk_i = ~clk_i;

    vac_datapath u_vac_datapath (.clk_i(clk_i), .nrst_i(nrst_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .test_flag_o(flag));

    // ----------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic access(input logic w, input logic [7:0] a,
                          input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        rd <= ~w;
        wr <= w;
        @(posedge clk_i);
        while (wait_o !== 1'b0)
        begin
            n++;
            if (n > 20)
            begin
                err_count++;
                $display("BAD t=%0t access never completed", $time);
                results();
            end
            @(posedge clk_i);
        end
        v = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        access(1'b1, a, d);
    endtask

    task automatic get(input logic [7:0] a, input logic [31:0] e,
                       input logic [31:0] msk = 32'hFFFF_FFFF);
        access(1'b0, a, 32'h0);
        check(v & msk, e);
    endtask

    task automatic cmd(input logic [3:0] op, input logic s);
        put(`VAC_OFF_CMD, {27'h0, s, op});
    endtask

    // ----------------------------------------------------------
    // tests
    // ----------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        get(`VAC_OFF_MODE, 32'h1);
        get(`VAC_OFF_ACC_A, 32'h0);
        get(`VAC_OFF_STATUS, 32'h0);
        put(8'h80, 32'hFFFF_FFFF);
        get(8'h80, 32'h0);
        put(`VAC_OFF_SELECTED, 32'h1234);
        get(`VAC_OFF_SELECTED, 32'h0);
        $display("test reset and refusals done");

        put(`VAC_OFF_OPER_X, 32'h10);
        put(`VAC_OFF_OPER_Y, 32'h0);
        put(`VAC_OFF_MULT_T, 32'h1);
        cmd(`VAC_OP_ADD_SUB, 1'b0);
        get(`VAC_OFF_ACC_A, 32'h0011_FFFF);
        cmd(`VAC_OP_SUB_ADD, 1'b1);
        get(`VAC_OFF_ACC_B, 32'h000F_0001);
        put(`VAC_OFF_MODE, 32'h0);
        cmd(`VAC_OP_ADD_SUB, 1'b0);
        get(`VAC_OFF_ACC_A, 32'h0010_0001);
        cmd(`VAC_OP_SUB_ADD, 1'b0);
        cmd(4'hF, 1'b0);
        get(`VAC_OFF_ACC_A, 32'h000F_FFFF);
        be <= 4'h3;
        put(`VAC_OFF_ACC_A, 32'hAAAA_5555);
        be <= 4'hF;
        get(`VAC_OFF_ACC_A, 32'h000F_5555);
        put(`VAC_OFF_MODE, 32'h1);
        $display("test dual arithmetic done");

        put(`VAC_OFF_BFLY, 32'h0);
        put(`VAC_OFF_HISTORY, 32'h0);
        hist = 16'h0;
        for (int j = 0; j < 8; j++)
        begin
            for (int s = 0; s < 2; s++)
            begin
                hi = s ? 16'hFFFB : 16'(j);
                lo = s ? 16'(j - 6) : (j[0] ? 16'(j + 1) : 16'(-j));
                tc = $signed(lo) > $signed(hi);
                sel = tc ? lo : hi;
                hist = {hist[14:0], tc};
                put(s ? `VAC_OFF_ACC_B : `VAC_OFF_ACC_A, {hi, lo});
                cmd(`VAC_OP_CMP_SEL, s[0]);
                get(`VAC_OFF_SELECTED, {16'h0, sel}, 32'hFFFF);
                check({31'h0, flag}, {31'h0, tc});
                get(8'(8'h40+4*j+32*s), {16'h0, sel}, 32'hFFFF);
            end
        end
        get(`VAC_OFF_HISTORY, {16'h0, hist}, 32'hFFFF);
        get(`VAC_OFF_STATUS, {30'h0, 1'b1, tc});
        put(`VAC_OFF_STATUS, 32'h2);
        get(`VAC_OFF_STATUS, {31'h0, tc});
        $display("test compare select done");

        put(`VAC_OFF_SOFT, {16'h0005, 16'h0030});
        for (int j = 0; j < 8; j++)
        begin
            m = (NEG0[j] ? -16'sd48 : 16'sd48)
                + (NEG1[j] ? -16'sd5 : 16'sd5);
            put(`VAC_OFF_BFLY, 32'(j));
            cmd(`VAC_OP_BRANCH_M, 1'b0);
            get(`VAC_OFF_MULT_T, {16'h0, m}, 32'hFFFF);
        end
        $display("test branch metric done");

        put(`VAC_OFF_OPER_X, 32'hFFFD);
        cmd(`VAC_OP_SQUARE, 1'b0);
        get(`VAC_OFF_ACC_A, 32'h9);
        put(`VAC_OFF_ACC_A, 32'h0002_0000);
        put(`VAC_OFF_OPER_X, 32'h4);
        cmd(`VAC_OP_MULT_ACC, 1'b0);
        get(`VAC_OFF_ACC_B, 32'h8);
        put(`VAC_OFF_ACC_B, 32'h64);
        put(`VAC_OFF_OPER_Y, 32'h5);
        cmd(`VAC_OP_MULT_SUB, 1'b0);
        get(`VAC_OFF_ACC_B, 32'h50);
        get(`VAC_OFF_MULT_T, 32'h4, 32'hFFFF);
        put(`VAC_OFF_BRC, 32'h7);
        cmd(`VAC_OP_COND_STORE, 1'b0);
        get(`VAC_OFF_CS_BRC, 32'h7, 32'hFFFF);
        get(`VAC_OFF_CS_MULT, 32'h4, 32'hFFFF);
        get(`VAC_OFF_CS_ACC, 32'h2, 32'hFFFF);
        put(`VAC_OFF_ACC_B, 32'h8000_0000);
        put(`VAC_OFF_BRC, 32'h9);
        put(`VAC_OFF_ACC_A, 32'h1234_0000);
        cmd(`VAC_OP_COND_STORE, 1'b0);
        get(`VAC_OFF_CS_BRC, 32'h7, 32'hFFFF);
        get(`VAC_OFF_CS_ACC, 32'h2, 32'hFFFF);
        put(`VAC_OFF_ACC_B, 32'h0);
        cmd(`VAC_OP_COND_STORE, 1'b0);
        get(`VAC_OFF_CS_BRC, 32'h9, 32'hFFFF);
        get(`VAC_OFF_CS_ACC, 32'h1234, 32'hFFFF);
        $display("test codebook ops done");

        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        check({31'h0, flag}, 32'h0);
        get(`VAC_OFF_MODE, 32'h1);
        $display("test second reset done");
        results();
    end
endmodule // tb
`default_nettype wire
